// ---- hw/dcsp_consts.svh ----
`ifndef DCSP_CONSTS_SVH
`define DCSP_CONSTS_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define DCSP_FRAME_BITS   16
`define DCSP_CNT_BITS     5
`define DCSP_DATA_BITS    10
`define DCSP_CMD_BITS     3
// falling edge on which the command field is complete
`define DCSP_CMD_EDGE     5'd5
// falling edge after which a configuration write takes effect
`define DCSP_CFG_EDGE     5'd14
// low configuration bits that are reserved and read as zero
`define DCSP_CFG_RSV_BITS 3

// ****************************************************************
// command codes
// ****************************************************************
`define DCSP_CMD_NOP      3'h0
`define DCSP_CMD_WR_CFG   3'h1
`define DCSP_CMD_RD_ERR   3'h4
`define DCSP_CMD_RD_CFG   3'h5

// ****************************************************************
// error word bit positions
// ****************************************************************
`define DCSP_ERR_INTERMIT 9
`define DCSP_ERR_SHORT    8
`define DCSP_ERR_OPEN     7
`define DCSP_ERR_OVERTEMP 6
`define DCSP_ERR_BROWNOUT 5

// ****************************************************************
// reset values
// ****************************************************************
`define DCSP_CFG_RST      10'h000
`define DCSP_ERR_RST      10'h000

`endif

// ---- hw/dcsp_fifo.sv ----
`timescale 1ns/1ps

module dcsp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : gBadParam
    $error("dcsp_fifo needs a power of two depth of at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH];            // storage array
  logic [AW-1:0]    wrPtr_reg, wrPtr_next;  // write pointer
  logic [AW-1:0]    rdPtr_reg, rdPtr_next;  // read pointer
  logic [AW:0]      cnt_reg, cnt_next;      // words in array
  logic             oValid_reg, oValid_next; // output stage full
  logic [WIDTH-1:0] oData_reg;              // registered read data
  logic             push;                   // word accepted
  logic             load;                   // array to output stage

  // output stage counts too, so DEPTH words in all, not one more
  assign inReady  = ((cnt_reg + (AW+1)'(oValid_reg)) != (AW+1)'(DEPTH));
  assign push     = inValid && inReady;
  // refill output stage when empty or being drained
  assign load     = (cnt_reg != '0) && (!oValid_reg || outReady);
  assign outValid = oValid_reg;
  assign outData  = oData_reg;

  // pointer and count arithmetic
  always_comb begin
    wrPtr_next  = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next  = load ? rdPtr_reg + 1'b1 : rdPtr_reg;
    cnt_next    = cnt_reg + (AW+1)'(push) - (AW+1)'(load);
    oValid_next = load ? 1'b1 : (outReady ? 1'b0 : oValid_reg);
  end

  // control registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_reg  <= '0;
      rdPtr_reg  <= '0;
      cnt_reg    <= '0;
      oValid_reg <= 1'b0;
    end else begin
      wrPtr_reg  <= wrPtr_next;
      rdPtr_reg  <= rdPtr_next;
      cnt_reg    <= cnt_next;
      oValid_reg <= oValid_next;
    end
  end

  // array write and registered read, no reset on storage
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
    if (load) begin
      oData_reg <= mem[rdPtr_reg];
    end
  end

endmodule // dcsp_fifo

// ---- hw/dcsp_pkg.sv ----
`include "dcsp_consts.svh"

package dcsp_pkg;

  // frame sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } dcsp_state_type;

  // one received frame, msb first on the wire
  typedef struct packed {
    logic [1:0]                   ignoredTop; // bits 15:14
    logic [`DCSP_CMD_BITS-1:0]    cmd;        // bits 13:11
    logic                         ignoredMid; // bit 10
    logic [`DCSP_DATA_BITS-1:0]   data;       // bits 9:0
  } dcsp_frame_type;

  // serial link pins, sampled together
  typedef struct packed {
    logic sclk;
    logic din;
    logic selA_n;
    logic selB_n;
  } dcsp_link_type;

  // raw fault detector levels
  typedef struct packed {
    logic shortCkt;
    logic openLoad;
    logic overTemp;
    logic brownout;
  } dcsp_fault_type;

endpackage

// ---- hw/dcsp_port.sv ----
`timescale 1ns/1ps
`include "dcsp_consts.svh"

// Operation
// - drive serial output while both selects low, until frame-done
// - ignore input data after frame-done until reselect
// - new cycle only on a later select fall
// - select high: release output, clear done, discard
// - frame-done after sixteen clocks past select fall
// - frame-done holds until a select rises
// - output stays released after the frame
// - chained device starts on upstream done edge
// - command bits 13:11, data bits 9:0
// - command zero: no effect, output zeros
// - command one writes config after edge fourteen
// - commands four, five read error and config
// - reserved commands two, three, six, seven: nothing
// - one error bit per condition, several allowed
// - intermittent bit only for short or open
// - interrupt only on a new error
// - error read releases interrupt until new error
// - first read releases, second read clears
// - selected only while both selects are low
module dcsp_port #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    sclkIn,
  input  wire logic                    dinIn,
  input  wire logic                    select_in_a_n,
  input  wire logic                    select_in_b_n,
  output logic                         doutOut,
  output logic                         doutOe,
  output logic                         frameDoneN,
  input  wire dcsp_pkg::dcsp_fault_type faultIn,
  output logic                         errorOut,
  output logic                         errorOe,
  output logic [`DCSP_DATA_BITS-1:0]   cfgOut,
  output dcsp_pkg::dcsp_frame_type     frameData,
  output logic                         frameValid,
  input  wire logic                    frameReady,
  output logic                         frameLost
);
  import dcsp_pkg::*;

  localparam int FB = `DCSP_FRAME_BITS;
  localparam int DB = `DCSP_DATA_BITS;

  if (FIFO_DEPTH < 2) begin : gBadDepth
    $error("dcsp_port needs a fifo depth of at least two");
  end

  // ****************************************************************
  // readback word selection
  // ****************************************************************
  // no-op and write return zeros, reserved codes too
  function automatic logic [DB-1:0] readWordOf(
    input logic [`DCSP_CMD_BITS-1:0] cmd,
    input logic [DB-1:0]             err,
    input logic [DB-1:0]             cfg
  );
    logic [DB-1:0] w;
    w = '0;
    if (cmd == `DCSP_CMD_RD_ERR) begin
      w = err;
    end else if (cmd == `DCSP_CMD_RD_CFG) begin
      w = cfg;
    end
    return w;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  dcsp_link_type  linkMeta_reg;   // first stage, read only below
  dcsp_link_type  linkSync_reg;   // second stage
  logic           sclkPrev_reg;   // edge finder history
  dcsp_fault_type faultMeta_reg;  // detector first stage
  dcsp_fault_type faultSync_reg;  // detector second stage
  dcsp_link_type  linkPins;       // pins gathered

  assign linkPins = '{sclk: sclkIn, din: dinIn,
                      selA_n: select_in_a_n, selB_n: select_in_b_n};

  // two flops on every outside level before any logic
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      linkMeta_reg  <= '{sclk: 1'b0, din: 1'b0, selA_n: 1'b0,
                         selB_n: 1'b0};
      linkSync_reg  <= '{sclk: 1'b0, din: 1'b0, selA_n: 1'b0,
                         selB_n: 1'b0};
      sclkPrev_reg  <= 1'b0;
      faultMeta_reg <= '0;
      faultSync_reg <= '0;
    end else begin
      linkMeta_reg  <= linkPins;
      linkSync_reg  <= linkMeta_reg;
      sclkPrev_reg  <= linkSync_reg.sclk;
      faultMeta_reg <= faultIn;
      faultSync_reg <= faultMeta_reg;
    end
  end

  logic selS;      // device selected
  logic sclkFall;  // one-cycle enable per falling sclk
  logic selRise;   // selection just began

  // selects act as one, so both must be low
  assign selS     = !linkSync_reg.selA_n && !linkSync_reg.selB_n;
  assign sclkFall = sclkPrev_reg && !linkSync_reg.sclk;

  // ****************************************************************
  // frame sequencer
  // ****************************************************************
  dcsp_state_type          state_reg, state_next;   // frame phase
  logic [`DCSP_CNT_BITS-1:0] cnt_reg, cnt_next;     // falling edges
  logic [FB-1:0]           rx_reg, rx_next;         // input shifter
  logic [FB-1:0]           tx_reg, tx_next;         // output shifter
  logic [`DCSP_CMD_BITS-1:0] cmd_reg, cmd_next;     // decoded command
  logic [DB-1:0]           cfg_reg, cfg_next;       // configuration
  logic                    selPrev_reg;             // select history
  logic                    doneEv;                  // frame complete
  logic [FB-1:0]           rxShift;                 // rx after edge
  logic [DB-1:0]           err_reg;                 // error word

  // reset to selected so a select held low at reset is no start
  assign selRise = selS && !selPrev_reg;
  assign rxShift = {rx_reg[FB-2:0], linkSync_reg.din};

  // next-state logic of the frame
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rx_next    = rx_reg;
    tx_next    = tx_reg;
    cmd_next   = cmd_reg;
    cfg_next   = cfg_reg;
    doneEv     = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        // a downstream part sees its select fall on the upstream
        // sixteenth edge, so its first bit is the next edge
        if (selRise) begin
          state_next = ST_SHIFT;
          cnt_next   = '0;
          rx_next    = '0;
          tx_next    = '0;
          cmd_next   = `DCSP_CMD_NOP;
        end
      end
      ST_SHIFT: begin
        if (!selS) begin
          // partial frame dropped; a config write past edge fourteen stays applied
          state_next = ST_IDLE;
        end else if (sclkFall) begin
          rx_next  = rxShift;
          cnt_next = cnt_reg + 1'b1;
          tx_next  = {tx_reg[FB-2:0], 1'b0};
          if (cnt_next == `DCSP_CMD_EDGE) begin
            // bits 15:11 are in, command sits in the low three
            cmd_next = rxShift[`DCSP_CMD_BITS-1:0];
            // bit 10 low, then the ten-bit word
            tx_next = {1'b0, readWordOf(rxShift[2:0], err_reg,
                       cfg_reg), 5'h00};
          end
          if (cnt_next == `DCSP_CFG_EDGE &&
              cmd_reg == `DCSP_CMD_WR_CFG) begin
            // bits 9:3 sit two places down after edge fourteen
            cfg_next = {rxShift[DB-3:`DCSP_CFG_RSV_BITS-2],
                        `DCSP_CFG_RSV_BITS'(0)};
          end
          if (cnt_next == 5'(FB)) begin
            state_next = ST_DONE;
            doneEv     = 1'b1;
          end
        end
      end
      ST_DONE: begin
        // further clocks and data are ignored here
        if (!selS) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // frame registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= '0;
      rx_reg      <= '0;
      tx_reg      <= '0;
      cmd_reg     <= `DCSP_CMD_NOP;
      cfg_reg     <= `DCSP_CFG_RST;
      selPrev_reg <= 1'b1;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      cmd_reg     <= cmd_next;
      cfg_reg     <= cfg_next;
      selPrev_reg <= selS;
    end
  end

  // output driven only mid-frame; zeros unless a readback
  assign doutOe     = (state_reg == ST_SHIFT);
  assign doutOut    = tx_reg[FB-1];
  assign frameDoneN = (state_reg != ST_DONE);
  assign cfgOut     = cfg_reg;

  // ****************************************************************
  // error register and interrupt
  // ****************************************************************
  logic [DB-1:0] err_next;     // error word next
  logic          irq_reg;      // interrupt pending
  logic          irq_next;
  logic          readOnce_reg; // first read taken
  logic          readOnce_next;
  logic [DB-1:0] curBits;      // faults present now
  logic          errRead;      // error readback completed
  logic          lostFault;    // stored short/open went away

  assign errRead = doneEv && (cmd_reg == `DCSP_CMD_RD_ERR);

  always_comb begin
    curBits = '0;
    curBits[`DCSP_ERR_SHORT]    = faultSync_reg.shortCkt;
    curBits[`DCSP_ERR_OPEN]     = faultSync_reg.openLoad;
    curBits[`DCSP_ERR_OVERTEMP] = faultSync_reg.overTemp;
    curBits[`DCSP_ERR_BROWNOUT] = faultSync_reg.brownout;
  end

  // only short and open count as intermittent
  assign lostFault =
    (err_reg[`DCSP_ERR_SHORT] && !faultSync_reg.shortCkt) ||
    (err_reg[`DCSP_ERR_OPEN] && !faultSync_reg.openLoad);

  // clears first, sets after, so an event in the clear cycle wins
  always_comb begin
    err_next      = err_reg;
    irq_next      = irq_reg;
    readOnce_next = readOnce_reg;
    if (errRead) begin
      irq_next = 1'b0;
      if (readOnce_reg) begin
        // second read keeps only faults still present
        err_next      = curBits;
        readOnce_next = 1'b0;
      end else begin
        readOnce_next = 1'b1;
      end
    end
    if (lostFault && !readOnce_reg) begin
      err_next[`DCSP_ERR_INTERMIT] = 1'b1;
    end
    if ((curBits & ~err_reg) != '0) begin
      // persisting or clearing faults raise nothing
      err_next      = err_next | curBits;
      irq_next      = 1'b1;
      readOnce_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      err_reg      <= `DCSP_ERR_RST;
      irq_reg      <= 1'b0;
      readOnce_reg <= 1'b0;
    end else begin
      err_reg      <= err_next;
      irq_reg      <= irq_next;
      readOnce_reg <= readOnce_next;
    end
  end

  // open-drain: only ever pulls low
  assign errorOut = 1'b0;
  assign errorOe  = irq_reg;

  // ****************************************************************
  // received frame stream
  // ****************************************************************
  logic fifoInReady; // space for a frame

  // the serial link cannot stall, so a full fifo drops the frame
  assign frameLost = doneEv && !fifoInReady;

  dcsp_fifo #(
    .WIDTH (FB),
    .DEPTH (FIFO_DEPTH)
  ) uFifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .inData   (rxShift),
    .inValid  (doneEv),
    .inReady  (fifoInReady),
    .outData  (frameData),
    .outValid (frameValid),
    .outReady (frameReady)
  );

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  selDrive_a: assert property (
    (state_reg == ST_SHIFT) |-> doutOe && frameDoneN)
    else $error("output not driven mid-frame");

  deselRelease_a: assert property (
    !selS |=> !doutOe && frameDoneN)
    else $error("deselect did not release the port");

  frameLen_a: assert property (
    $fell(frameDoneN) |-> $past(cnt_reg) == 5'd15 && $past(sclkFall))
    else $error("frame done not on the sixteenth edge");

  doneHold_a: assert property (
    !frameDoneN && selS |=> !frameDoneN && !doutOe)
    else $error("frame done dropped while selected");

  doneIgnore_a: assert property (
    state_reg == ST_DONE |=> $stable(rx_reg))
    else $error("data taken after frame done");

  startOnFall_a: assert property (
    $rose(doutOe) |-> $past(selRise) && $past(selS, 2) == 1'b0)
    else $error("frame started without a select fall");

  cfgWrite_a: assert property (
    !$stable(cfg_reg) |-> $past(cmd_reg) == `DCSP_CMD_WR_CFG &&
      $past(cnt_reg) == 5'd13 && $past(sclkFall))
    else $error("configuration changed outside a write");

  quietOut_a: assert property (
    doutOe && (cmd_reg == `DCSP_CMD_NOP ||
      cmd_reg == `DCSP_CMD_WR_CFG) |-> !doutOut)
    else $error("output not low on no-op or write");

  readRelease_a: assert property (
    errRead && (curBits & ~err_reg) == '0 |=> !errorOe[*2])
    else $error("interrupt kept after error read");

  intermit_a: assert property (
    $rose(err_reg[`DCSP_ERR_INTERMIT]) |->
      $past(lostFault) && !$past(readOnce_reg))
    else $error("intermittent set without a lost fault");

  irqNew_a: assert property (
    $rose(errorOe) |-> ($past(curBits) & ~$past(err_reg)) != '0)
    else $error("interrupt raised without a new error");

  covFrame_c: cover property ($fell(frameDoneN) ##[1:1000] frameDoneN);
  covWrite_c: cover property (!$stable(cfg_reg));
  covRead_c:  cover property (errRead ##[1:1000] errRead);
  covLost_c:  cover property (frameLost);

endmodule // dcsp_port

// ---- verification/daisy_chain_spi_command_port_bench.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end

// ****************************************************************
// bench top
// ****************************************************************
module daisy_chain_spi_command_port_bench;
  import dcsp_pkg::*;
  logic           ref_clk = 1'b0;  // 200 MHz
  logic           resetn = 1'b0;   // async, active low
  logic           frameReady = 1'b1;
  dcsp_fault_type faultIn = 4'h0;  // raw fault levels
  logic           sclk, din, selA_n, selB_n;
  logic           doutOut, doutOe, frameDoneN, errorOe, errorOut;
  logic           frameValid, frameLost;
  logic [9:0]     cfgOut;
  dcsp_frame_type frameData;
  wire            doutWire = doutOe ? doutOut : 1'b1; // pull-up
  int             errors = 0;
  int             cmp_count = 0;
  int             lostCnt = 0;     // frames dropped
  int             popCnt = 0;      // fifo pops

  always #2.5 ref_clk = ~ref_clk;

  dcsp_master m (.sclk(sclk), .din(din), .selA_n(selA_n),
                 .selB_n(selB_n), .doutWire(doutWire));

  dcsp_port #(.FIFO_DEPTH(16)) uut (
    .ref_clk(ref_clk), .resetn(resetn), .sclkIn(sclk), .dinIn(din),
    .select_in_a_n(selA_n), .select_in_b_n(selB_n),
    .doutOut(doutOut), .doutOe(doutOe), .frameDoneN(frameDoneN),
    .faultIn(faultIn), .errorOut(errorOut), .errorOe(errorOe),
    .cfgOut(cfgOut), .frameData(frameData), .frameValid(frameValid),
    .frameReady(frameReady), .frameLost(frameLost));

  // fifo event counters, only for the checks
  always @(posedge ref_clk) begin
    if (frameLost === 1'b1) lostCnt++;
    if (frameValid === 1'b1 && frameReady === 1'b1) popCnt++;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  // one selected frame, then deselect and check the idle state
  task automatic frame(input logic [15:0] w, input int n,
                       input logic [15:0] ex);
    logic [15:0] rx;
    m.sel(1'b0, 1'b0);
    m.xfer(w, n, rx);
    `CHK("rx", ex, rx)
    `CHK("oe", n < 16, doutOe)
    `CHK("done", n < 16, frameDoneN)
    m.sel(1'b1, 1'b1);
    `CHK("oe off", 1'b0, doutOe)
    `CHK("done off", 1'b1, frameDoneN)
  endtask

  // fault levels change off the sampling edge
  task automatic flt(input logic [3:0] v);
    @(negedge ref_clk) faultIn = v;
    repeat (10) @(negedge ref_clk);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  initial begin
    #400000;
    errors++;
    close_out();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [15:0] rx;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (10) @(negedge ref_clk);
    // selects low across reset must not open a frame
    `CHK("rst oe", 1'b0, doutOe)
    `CHK("rst cfg", 10'h000, cfgOut)
    `CHK("rst err", 1'b0, errorOe)
    m.sel(1'b1, 1'b1);
    $display("test reset done");

    // write with ignored bits set; low three config bits stay zero
    frame(16'hcfff, 16, 16'h0000);
    `CHK("cfg", 10'h3f8, cfgOut)
    // extra clocks while still selected change nothing
    m.sel(1'b0, 1'b0);
    m.xfer(16'hcfff, 16, rx);
    m.xfer(16'h0800, 16, rx);
    `CHK("extra rx", 16'hffff, rx)
    `CHK("extra cfg", 10'h3f8, cfgOut)
    m.sel(1'b1, 1'b1);
    frame(16'h2800, 16, 16'h03f8);
    $display("test config done");

    // aborts: past edge fourteen applies, before it is lost
    frame(16'h0955, 15, 16'h0000);
    `CHK("abort15", 10'h150, cfgOut)
    frame(16'h0a00, 13, 16'h0000);
    `CHK("abort13", 10'h150, cfgOut)
    for (int c = 0; c < 8; c++) begin
      if (c == 1 || c == 4 || c == 5) continue;
      frame({2'b00, 3'(c), 11'h7ff}, 16, 16'h0000);
      `CHK("nop cfg", 10'h150, cfgOut)
    end
    // one select alone does not select
    m.sel(1'b0, 1'b1);
    `CHK("a only", 1'b0, doutOe)
    m.sel(1'b1, 1'b0);
    `CHK("b only", 1'b0, doutOe)
    m.sel(1'b1, 1'b1);
    $display("test commands done");

    // interrupt policy
    flt(4'h8);
    `CHK("irq new", 1'b1, errorOe)
    `CHK("irq pin", 1'b0, errorOut)
    frame(16'h2000, 16, 16'h0100);
    flt(4'h8);
    `CHK("irq held", 1'b0, errorOe)
    flt(4'h9);
    `CHK("irq second", 1'b1, errorOe)
    frame(16'h2000, 16, 16'h0120);
    flt(4'h0);
    frame(16'h2000, 16, 16'h0120);
    frame(16'h2000, 16, 16'h0000);
    // transient open load sets the intermittent bit
    flt(4'h4);
    flt(4'h0);
    frame(16'h2000, 16, 16'h0280);
    frame(16'h2000, 16, 16'h0280);
    frame(16'h2000, 16, 16'h0000);
    // transient overtemperature does not
    flt(4'h2);
    flt(4'h0);
    frame(16'h2000, 16, 16'h0040);
    $display("test errors done");

    // fifo: fill past depth with consumer stalled, then drain
    @(negedge ref_clk) frameReady = 1'b0;
    for (int i = 1; i <= 17; i++)
      frame(16'(i), 16, 16'h0000);
    `CHK("lost", 1, lostCnt)
    `CHK("head", 16'h0001, frameData)
    popCnt = 0;
    @(negedge ref_clk) frameReady = 1'b1;
    repeat (60) @(negedge ref_clk);
    `CHK("pops", 16, popCnt)
    `CHK("empty", 1'b0, frameValid)
    $display("test fifo done");
    close_out();
  end
endmodule // daisy_chain_spi_command_port_bench

// ---- verification/dcsp_master.sv ----
`timescale 1ns/1ps

// ****************************************************************
// spi master model, clock idles low
// ****************************************************************
module dcsp_master (
  output logic      sclk,     // serial clock, still between frames
  output logic      din,      // serial data to the device
  output logic      selA_n,   // shared select
  output logic      selB_n,   // second select
  input  wire logic doutWire  // resolved dout line
);
  // selects start low so a select held over reset is seen
  initial begin
    sclk   = 1'b0;
    din    = 1'b0;
    selA_n = 1'b0;
    selB_n = 1'b0;
  end

  // set both selects, then let the synchronisers settle
  task automatic sel(input logic a, input logic b);
    selA_n = a;
    selB_n = b;
    #120;
  endtask

  // n clocks of 48 ns, msb first; dout taken on rising edges
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = 0; i < n; i++) begin
      #24 sclk = 1'b1;
      rx = {rx[14:0], doutWire};
      // data moves on the rise so it stands still at the fall
      din = (i < 16) ? w[15 - i] : ~din;
      #24 sclk = 1'b0;
    end
    // released data line must not look stable
    #24 din = ~din;
    #96;
  endtask
endmodule // dcsp_master
